// file: src/line_buffer_pkg.sv
// ****************************************************************
// Line buffer constants
// ****************************************************************
package line_buffer_pkg;

  // Array shape
  localparam int WORDS = 5048;
  localparam int ADDR_W = 13;
  localparam int DATA_W = 8;
  localparam logic [ADDR_W-1:0] ADDR_FIRST = 13'h0000;
  localparam logic [ADDR_W-1:0] ADDR_LAST = 13'(WORDS - 1);
  localparam logic [ADDR_W-1:0] ADDR_ONE = 13'h0001;

  // Delay limits at full clock rate
  localparam int MIN_DELAY = 10;
  localparam logic [ADDR_W-1:0] DELAY_MIN = 13'(MIN_DELAY);
  localparam logic [ADDR_W-1:0] DELAY_MAX = 13'(WORDS);

  // Output buffer depth
  localparam int OUT_DEPTH = 2;

  // Data hold time and its count at the 4 ns clock
  localparam int CLK_PERIOD_NS = 4;
  localparam int NS_PER_MS = 1000000;
  localparam int HOLD_TIME_MS = 5;
  localparam int HOLD_CYC = HOLD_TIME_MS * NS_PER_MS / CLK_PERIOD_NS;

endpackage

// file: src/line_buffer_if.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Pin-level link between controller and line buffer
// ****************************************************************
interface line_buffer_if;
  import line_buffer_pkg::*;

  // Write port
  logic write_port_clock;
  logic write_port_enable_n;
  logic write_pointer_clear_n;
  logic [DATA_W-1:0] write_data_in;

  // Read port
  logic read_port_clock;
  logic read_port_enable_n;
  logic read_pointer_clear_n;
  logic [DATA_W-1:0] read_data_out;
  logic read_data_oe;

  modport dev (
    input write_port_clock,
    input write_port_enable_n,
    input write_pointer_clear_n,
    input write_data_in,
    input read_port_clock,
    input read_port_enable_n,
    input read_pointer_clear_n,
    output read_data_out,
    output read_data_oe
  );

  modport ctl (
    output write_port_clock,
    output write_port_enable_n,
    output write_pointer_clear_n,
    output write_data_in,
    output read_port_clock,
    output read_port_enable_n,
    output read_pointer_clear_n,
    input read_data_out,
    input read_data_oe
  );
endinterface
`default_nettype wire

// file: src/line_delay_buffer.sv
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// Two-entry output buffer
// ****************************************************************
// Shift-style queue so the head entry is always a flip-flop
module pair_buffer
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
)
(
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic clk_en_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic [$clog2(DEPTH+1)-1:0] level_o,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int LW = $clog2(DEPTH + 1);
  localparam logic [LW-1:0] LEVEL_EMPTY = '0;
  localparam logic [LW-1:0] LEVEL_FULL = LW'(DEPTH);
  localparam logic [LW-1:0] LEVEL_STEP = LW'(1);

  logic [WIDTH-1:0] slot_reg [DEPTH];
  logic [LW-1:0] level_reg;
  logic [LW-1:0] level_next;
  logic [LW-1:0] write_pos;
  logic valid_reg;
  wire push = in_valid_i && in_ready_o;
  wire pop = out_valid_o && out_ready_i;

  // Full from the level; valid has its own flop so the output is registered
  assign in_ready_o = (level_reg != LEVEL_FULL);
  assign out_valid_o = valid_reg;
  assign level_o = level_reg;
  assign out_data_o = slot_reg[0];
  // Push lands behind whatever survives the pop
  assign write_pos = pop ? level_reg - LEVEL_STEP : level_reg;
  assign level_next = level_reg + (push ? LEVEL_STEP : LEVEL_EMPTY)
                    - (pop ? LEVEL_STEP : LEVEL_EMPTY);

  // Level count and its registered not-empty copy
  always_ff @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
    begin
      level_reg <= LEVEL_EMPTY;
      valid_reg <= 1'b0;
    end
    else if (clk_en_i)
    begin
      level_reg <= level_next;
      valid_reg <= (level_next != LEVEL_EMPTY);
    end
  end

  // One entry per slot; data needs no reset
  for (genvar i = 0; i < DEPTH; i++)
  begin : g_slot
    wire take_in = push && (write_pos == LW'(i));
    wire [WIDTH-1:0] behind = (i + 1 < DEPTH) ? slot_reg[(i + 1) % DEPTH] : slot_reg[i];
    always_ff @(posedge ref_clk_i)
    begin
      if (clk_en_i)
      begin
        if (take_in)
          slot_reg[i] <= in_data_i;
        else if (pop)
          slot_reg[i] <= behind;
      end
    end
  end
endmodule

// ****************************************************************
// Line delay buffer, device end
// ****************************************************************
// Overview of operation
// - Controller clears both pointers before use.
// - Pointer clear works whatever the enable.
// - Access only on port step, enable low.
// - Written word readable well within bound.
// - First read after clear gives word zero.
// - Reads nondestructive; controller honours hold time.
// - Writes and reads run from address zero.
// - Write and read ports fully independent.
// - Joint clear, no disables: 5048 cycle delay.
// - Write disables shorten the delay.
// - Read disables lengthen the delay.
// - Controller keeps delay within 10..5048.
// - Read clear m after write: delay m.
// - Joint clear each line replays previous line.
// - Disable plus clear plus line within hold.
// - Pointer steps when enabled, wraps 5047 to 0.
// - Read enable high floats outputs, holds pointer.
// - Low clear at port step zeroes pointer.
// - Write controls and data taken at step.
module line_delay_buffer
(
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic clk_en_i,
  line_buffer_if.dev lb,
  output logic [line_buffer_pkg::DATA_W-1:0] out_data_o,
  output logic out_valid_o,
  input wire logic out_ready_i
);
  import line_buffer_pkg::*;

  localparam int LW = $clog2(OUT_DEPTH + 1);
  localparam logic [LW:0] ROOM_BASE = (LW+1)'(OUT_DEPTH);

  // ****************************************************************
  // Storage and pointers
  // ****************************************************************
  logic [DATA_W-1:0] cell_mem [WORDS];
  logic [ADDR_W-1:0] wr_ptr_reg;
  logic [ADDR_W-1:0] wr_ptr_next;
  logic [ADDR_W-1:0] rd_ptr_reg;
  logic [ADDR_W-1:0] rd_ptr_next;
  logic [DATA_W-1:0] rd_data_reg;
  logic rd_oe_reg;
  logic push_reg;
  logic [LW-1:0] out_level;
  logic out_in_ready;

  // Pointer advance with wrap at the last word
  function automatic logic [ADDR_W-1:0] step_addr(input logic [ADDR_W-1:0] a);
    step_addr = (a == ADDR_LAST) ? ADDR_FIRST : a + ADDR_ONE;
  endfunction

  // ****************************************************************
  // Write port decode
  // ****************************************************************
  // write only when enabled
  wire wr_step = lb.write_port_clock;
  wire wr_go = wr_step && !lb.write_port_enable_n;
  wire wr_clr = wr_step && !lb.write_pointer_clear_n;
  // clear cycle itself addresses word zero
  wire [ADDR_W-1:0] wr_addr = wr_clr ? ADDR_FIRST : wr_ptr_reg;
  assign wr_ptr_next = wr_go ? step_addr(wr_addr) : wr_addr;

  // ****************************************************************
  // Read port decode
  // ****************************************************************
  // Words already owed to the output queue, less one leaving now
  wire out_pop = out_valid_o && out_ready_i;
  wire [LW:0] owed = (LW+1)'(out_level) + (LW+1)'(push_reg);
  wire [LW:0] room = ROOM_BASE + (LW+1)'(out_pop);
  // A stalled receiver acts like a read disable, so no word is lost
  wire space_ok = owed < room;
  wire rd_step = lb.read_port_clock;
  // stalled or disabled reads leave the pointer behind
  wire rd_go = rd_step && !lb.read_port_enable_n && space_ok;
  wire rd_clr = rd_step && !lb.read_pointer_clear_n;
  // first read after clear is word zero
  wire [ADDR_W-1:0] rd_addr = rd_clr ? ADDR_FIRST : rd_ptr_reg;
  assign rd_ptr_next = rd_go ? step_addr(rd_addr) : rd_addr;

  // ****************************************************************
  // Write side state
  // ****************************************************************
  // write pointer runs from zero
  always_ff @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
      wr_ptr_reg <= ADDR_FIRST;
    else if (clk_en_i && wr_step)
      wr_ptr_reg <= wr_ptr_next;
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (clk_en_i && wr_go)
      cell_mem[wr_addr] <= lb.write_data_in;
  end

  // ****************************************************************
  // Read side state
  // ****************************************************************
  // read pointer owes nothing to the write side
  always_ff @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
      rd_ptr_reg <= ADDR_FIRST;
    else if (clk_en_i && rd_step)
      rd_ptr_reg <= rd_ptr_next;
  end

  // read sees the old word when both hit one address
  // a read never disturbs the cell
  always_ff @(posedge ref_clk_i)
  begin
    if (clk_en_i && rd_go)
      rd_data_reg <= cell_mem[rd_addr];
  end

  // outputs float while reads are disabled
  always_ff @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
      rd_oe_reg <= 1'b0;
    else if (clk_en_i && rd_step)
      rd_oe_reg <= !lb.read_port_enable_n;
  end

  // One-cycle mark that a fresh word sits in the read register
  always_ff @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
      push_reg <= 1'b0;
    else if (clk_en_i)
      push_reg <= rd_go;
  end

  assign lb.read_data_out = rd_data_reg;
  assign lb.read_data_oe = rd_oe_reg;

  // ****************************************************************
  // Output queue toward the receiver
  // ****************************************************************
  // Space check above guarantees the queue is ready on every push
  pair_buffer #(
    .WIDTH(DATA_W),
    .DEPTH(OUT_DEPTH)
  ) u_out_queue (
    .ref_clk_i(ref_clk_i),
    .sys_rst_i(sys_rst_i),
    .clk_en_i(clk_en_i),
    .in_valid_i(push_reg),
    .in_ready_o(out_in_ready),
    .in_data_i(rd_data_reg),
    .level_o(out_level),
    .out_valid_o(out_valid_o),
    .out_ready_i(out_ready_i),
    .out_data_o(out_data_o)
  );

  // Ready is implied by the space check; kept for the queue's contract
  wire unused_ready = out_in_ready;
endmodule
`default_nettype wire

// file: src/line_delay_controller.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Line delay controller, far end
// ****************************************************************
module line_delay_controller
#(
  parameter int HOLD_LIMIT_CYC = line_buffer_pkg::HOLD_CYC
)
(
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic clk_en_i,
  line_buffer_if.ctl lb,
  input wire logic start_i,
  input wire logic line_mode_i,
  input wire logic [line_buffer_pkg::ADDR_W-1:0] delay_i,
  input wire logic [line_buffer_pkg::DATA_W-1:0] in_data_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  output logic running_o
);
  import line_buffer_pkg::*;

  typedef enum logic [1:0] {ST_IDLE, ST_LEAD, ST_RUN} ctl_state_e;

  // the line may not outlast the hold time
  localparam logic [ADDR_W-1:0] SPAN_MAX =
    (HOLD_LIMIT_CYC < WORDS) ? ADDR_W'(HOLD_LIMIT_CYC) : DELAY_MAX;

  ctl_state_e state_reg;
  ctl_state_e state_next;
  logic [ADDR_W-1:0] span_reg;
  logic [ADDR_W-1:0] cnt_reg;
  logic line_mode_reg;
  logic wclr_n_reg;
  logic rclr_n_reg;
  logic wstep_reg;
  logic rstep_reg;
  logic wen_n_reg;
  logic ren_n_reg;
  logic [DATA_W-1:0] wdata_reg;

  // ****************************************************************
  // Decode
  // ****************************************************************
  // clamp the delay into the legal range
  wire [ADDR_W-1:0] span_lo = (delay_i < DELAY_MIN) ? DELAY_MIN : delay_i;
  wire [ADDR_W-1:0] span_sel = (span_lo > SPAN_MAX) ? SPAN_MAX : span_lo;
  wire span_done = (cnt_reg == span_reg);
  wire take_in = in_valid_i && in_ready_o;
  // start clears write port, read port with it in line mode
  wire do_start = start_i;
  // read clear follows write clear by the span
  wire lead_end = (state_reg == ST_LEAD) && span_done;
  wire line_wrap = (state_reg == ST_RUN) && line_mode_reg && span_done;
  wire wclr_now = do_start || line_wrap;
  wire rclr_now = (do_start && line_mode_i) || lead_end || line_wrap;

  // Next state
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: state_next = ST_IDLE;
      ST_LEAD: if (span_done) state_next = ST_RUN;
      ST_RUN: state_next = ST_RUN;
      default: state_next = ST_IDLE;
    endcase
    if (do_start)
      state_next = line_mode_i ? ST_RUN : ST_LEAD;
  end

  // ****************************************************************
  // Sequencing state
  // ****************************************************************
  always_ff @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
    begin
      state_reg <= ST_IDLE;
      span_reg <= DELAY_MIN;
      line_mode_reg <= 1'b0;
      cnt_reg <= ADDR_ONE;
    end
    else if (clk_en_i)
    begin
      state_reg <= state_next;
      if (do_start)
      begin
        span_reg <= span_sel;
        line_mode_reg <= line_mode_i;
      end
      cnt_reg <= (wclr_now || span_done) ? ADDR_ONE : cnt_reg + ADDR_ONE;
    end
  end

  // ****************************************************************
  // Pin drive, all from flip-flops
  // ****************************************************************
  // a missing input word is a write disable
  always_ff @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
    begin
      wstep_reg <= 1'b0;
      rstep_reg <= 1'b0;
      wen_n_reg <= 1'b1;
      ren_n_reg <= 1'b1;
      wclr_n_reg <= 1'b1;
      rclr_n_reg <= 1'b1;
      wdata_reg <= '0;
      in_ready_o <= 1'b0;
      running_o <= 1'b0;
    end
    else if (clk_en_i)
    begin
      wstep_reg <= (state_next != ST_IDLE);
      rstep_reg <= (state_next != ST_IDLE);
      wen_n_reg <= !take_in;
      // Reads start with the read clear
      ren_n_reg <= !(state_next == ST_RUN);
      wclr_n_reg <= !wclr_now;
      rclr_n_reg <= !rclr_now;
      wdata_reg <= in_data_i;
      in_ready_o <= (state_next != ST_IDLE);
      running_o <= (state_next == ST_RUN);
    end
  end

  assign lb.write_port_clock = wstep_reg;
  assign lb.read_port_clock = rstep_reg;
  assign lb.write_port_enable_n = wen_n_reg;
  assign lb.read_port_enable_n = ren_n_reg;
  assign lb.write_pointer_clear_n = wclr_n_reg;
  assign lb.read_pointer_clear_n = rclr_n_reg;
  assign lb.write_data_in = wdata_reg;
endmodule
`default_nettype wire

// file: verification/line_buffer_checker.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Pin checker for the line buffer link
// ****************************************
module line_buffer_checker
  import line_buffer_pkg::*;
#(
  parameter int HOLD_LIMIT_CYC = HOLD_CYC
)
(
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic clk_en_i,
  input wire logic write_port_clock,
  input wire logic write_port_enable_n,
  input wire logic write_pointer_clear_n,
  input wire logic [DATA_W-1:0] write_data_in,
  input wire logic read_port_clock,
  input wire logic read_port_enable_n,
  input wire logic read_pointer_clear_n,
  input wire logic [DATA_W-1:0] read_data_out,
  input wire logic read_data_oe
);
  logic [ADDR_W-1:0] wptr_reg;
  logic [ADDR_W-1:0] since_reg;
  logic [DATA_W-1:0] w0_reg;
  logic w0_ok = 1'b0;

  // Step decode; a frozen clock enable means no step at all
  wire w_step = clk_en_i && write_port_clock;
  wire r_step = clk_en_i && read_port_clock;
  wire w_clr = w_step && !write_pointer_clear_n;
  wire [ADDR_W-1:0] w_addr = w_clr ? ADDR_FIRST : wptr_reg;
  wire w_zero = w_step && !write_port_enable_n && (w_addr == ADDR_FIRST);
  wire pins_idle = !write_port_clock && !read_port_clock && write_pointer_clear_n
    && read_pointer_clear_n && write_port_enable_n && read_port_enable_n && !read_data_oe;

  // Shadow write pointer, so word zero is known even after a wrap
  always_ff @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
      wptr_reg <= ADDR_FIRST;
    else if (w_step && !write_port_enable_n)
      wptr_reg <= (w_addr == ADDR_LAST) ? ADDR_FIRST : w_addr + ADDR_ONE;
    else if (w_clr)
      wptr_reg <= ADDR_FIRST;
  end

  // Enabled cycles since the last write clear; saturates so stale clears look far off
  always_ff @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
      since_reg <= '1;
    else if (w_clr)
      since_reg <= ADDR_ONE;
    else if (clk_en_i && since_reg != '1)
      since_reg <= since_reg + ADDR_ONE;
  end

  // Storage survives reset, so the word zero copy does too
  always_ff @(posedge ref_clk_i)
  begin
    if (w_zero)
    begin
      w0_reg <= write_data_in;
      w0_ok <= 1'b1;
    end
  end

  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);

  sequence s_clear_read;
    r_step && !read_pointer_clear_n && !read_port_enable_n && w0_ok;
  endsequence
  sequence s_word0_out;
    read_data_oe && (read_data_out == $past(w0_reg));
  endsequence
  sequence s_no_wclear;
    !w_clr [*8];
  endsequence

  a_reset_idle: assert property ($fell(sys_rst_i) |-> pins_idle)
    else $error("link pins not idle after reset");
  a_read_hold: assert property (!(r_step && !(read_port_enable_n && read_pointer_clear_n))
    |=> $stable(read_data_out)) else $error("read data moved without a read");
  a_read_float: assert property (r_step && read_port_enable_n && read_pointer_clear_n
    |=> !read_data_oe) else $error("read output driven after disabled step");
  a_oe_stable: assert property (!r_step |=> $stable(read_data_oe))
    else $error("output enable moved without a read step");
  a_clear_word: assert property (s_clear_read |=> s_word0_out)
    else $error("first read after clear is not word zero");
  a_delay_span: assert property (r_step && !read_pointer_clear_n && !w_clr
    |-> since_reg >= DELAY_MIN && since_reg <= HOLD_LIMIT_CYC)
    else $error("read clear outside delay range");
  a_line_span: assert property (w_clr && !read_pointer_clear_n |-> since_reg >= DELAY_MIN)
    else $error("line period too short");
  a_clear_gap: assert property (w_clr |=> s_no_wclear)
    else $error("write clears too close");
endmodule
`default_nettype wire

// file: verification/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Link bench: controller drives the buffer
// ****************************************
module tb_top;
  import line_buffer_pkg::*;
  localparam int HOLD = 64;
  localparam int LIMIT = 20000;
  logic ref_clk_i;
  logic sys_rst_i = 1'b1;
  logic clk_en_i = 1'b1;
  logic start_i = 1'b0;
  logic line_mode_i = 1'b0;
  logic [ADDR_W-1:0] delay_i = '0;
  logic [DATA_W-1:0] in_data_i = '0;
  logic in_valid_i = 1'b0;
  logic in_ready_o;
  logic running_o;
  logic [DATA_W-1:0] out_data_o;
  logic out_valid_o;
  logic out_ready_i = 1'b1;
  logic rand_ready = 1'b0;
  logic rand_en = 1'b0;
  int err_count = 0;
  int total_checks = 0;
  int cycles = 0;
  logic [DATA_W-1:0] exp_q[$];
  logic [DATA_W-1:0] exp_w;

  line_buffer_if lb();
  line_delay_buffer u_line_delay_buffer (.ref_clk_i, .sys_rst_i, .clk_en_i, .lb(lb),
    .out_data_o, .out_valid_o, .out_ready_i);
  line_delay_controller #(.HOLD_LIMIT_CYC(HOLD)) u_line_delay_controller (.ref_clk_i,
    .sys_rst_i, .clk_en_i, .lb(lb), .start_i, .line_mode_i, .delay_i, .in_data_i,
    .in_valid_i, .in_ready_o, .running_o);
  line_buffer_checker #(.HOLD_LIMIT_CYC(HOLD)) u_line_buffer_checker (.ref_clk_i,
    .sys_rst_i, .clk_en_i, .write_port_clock(lb.write_port_clock),
    .write_port_enable_n(lb.write_port_enable_n),
    .write_pointer_clear_n(lb.write_pointer_clear_n), .write_data_in(lb.write_data_in),
    .read_port_clock(lb.read_port_clock), .read_port_enable_n(lb.read_port_enable_n),
    .read_pointer_clear_n(lb.read_pointer_clear_n), .read_data_out(lb.read_data_out),
    .read_data_oe(lb.read_data_oe));

  // Clock
  initial
  begin
    ref_clk_i = 1'b0;
    forever #2 ref_clk_i = ~ref_clk_i;
  end

  task automatic summarize();
    if (err_count == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic check(input logic ok, input string msg);
    total_checks++;
    if (ok !== 1'b1)
    begin
      err_count++;
      $display("FAIL %0t %s", $time, msg);
    end
  endtask

  // Receiver stalls and clock freezes, plus the hang limit
  always @(posedge ref_clk_i)
  begin
    out_ready_i <= !rand_ready || ($urandom % 4 != 0);
    clk_en_i <= !rand_en || ($urandom % 4 != 0);
    cycles++;
    if (cycles == LIMIT)
    begin
      err_count++;
      $display("FAIL %0t timeout", $time);
      summarize();
    end
  end

  // Output side takes the oldest note; stale reads past the stream are ignored
  always @(posedge ref_clk_i)
  begin
    if (out_valid_o === 1'b1 && out_ready_i && clk_en_i && exp_q.size() > 0)
    begin
      exp_w = exp_q.pop_front();
      check(out_data_o === exp_w, "stream word mismatch");
    end
  end

  // Start a run, stream n words with one short write gap midway, then drain
  task automatic run_stream(input logic mode, input logic [ADDR_W-1:0] dly, input int n,
    input logic rdy, input logic en);
    int sent;
    int gap;
    sent = 0;
    gap = 0;
    @(posedge ref_clk_i);
    start_i <= 1'b1;
    line_mode_i <= mode;
    delay_i <= dly;
    @(posedge ref_clk_i);
    start_i <= 1'b0;
    // Let leftovers of the previous run leave the output queue first
    repeat (5) @(posedge ref_clk_i);
    in_valid_i <= 1'b1;
    rand_ready <= rdy;
    while (sent < n)
    begin
      @(posedge ref_clk_i);
      if (in_valid_i && in_ready_o === 1'b1 && clk_en_i)
      begin
        if (!mode)
          exp_q.push_back(in_data_i);
        sent++;
        in_data_i <= 8'($urandom);
      end
      gap = gap + ((sent == n / 2) ? 1 : 0);
      // Three missed writes stay inside the shortest span's lead over the reads
      in_valid_i <= ((sent != n / 2) || (gap > 3)) && (sent < n);
      rand_en <= en && (sent > 20) && (sent < n);
    end
    check(running_o === 1'b1, "controller not running");
    repeat (400)
      if (exp_q.size() != 0)
        @(posedge ref_clk_i);
    check(exp_q.size() == 0, "words lost");
    rand_ready <= 1'b0;
  endtask

  // Main sequence
  initial
  begin
    void'($urandom(76022));
    repeat (3) @(posedge ref_clk_i);
    sys_rst_i <= 1'b0;
    run_stream(1'b0, 13'h0064, 300, 1'b1, 1'b0);
    run_stream(1'b0, 13'h0005, 5100, 1'b0, 1'b1);
    run_stream(1'b1, 13'h0014, 120, 1'b0, 1'b0);
    sys_rst_i <= 1'b1;
    repeat (2) @(posedge ref_clk_i);
    sys_rst_i <= 1'b0;
    @(posedge ref_clk_i);
    check(!running_o && !out_valid_o && !in_ready_o, "reset state");
    run_stream(1'b0, 13'h000c, 60, 1'b1, 1'b0);
    summarize();
  end
endmodule
`default_nettype wire
